// *** tuch_top.sv ***
// command handler of the timing unit: trace, time, leap and holdover
//
// Operation
// (RULE1) trace period is setting times 50 ms
// (RULE2) trace record holds six float values
// (RULE3) tilt derived from acceleration, may exceed 90
// (RULE4) trace destination select and query
// (RULE5) compensation only with factory calibration
// (RULE6) calibration computes gain and offset per axis
// (RULE7) acceleration query returns three axes
// (RULE8) date query returns UTC year month day
// (RULE9) time query returns UTC 24-hour time
// (RULE10) time string is hh:mm:ss
// (RULE11) timekeeping interval equals loop interval
// (RULE12) broadcast date and time sentences each second
// (RULE13) receiver unit uses external pulse reference
// (RULE14) leap pending is 1 only with almanac
// (RULE15) leap offset stored until almanac arrives
// (RULE16) final minute 59/60/61 with almanac, else 0
// (RULE17) combined leap query returns four results
// (RULE18) combined timekeeping query returns five results
// (RULE19) loop queries report selected servo loop
// (RULE20) holdover length in seconds plus state
// (RULE21) forced holdover stops primary disciplining
// (RULE22) primary interval still measured in holdover
// (RULE23) release command ends forced holdover
// (RULE24) trace count restarts on setting change
`timescale 1ns/1ps
`default_nettype none
module tuch_top (
    input wire logic clk_in,
    input wire logic rstn_in,
    input wire logic cmd_valid_in,
    input wire tuch_pkg::tuch_cmd_t cmd_in,
    input wire logic trace_set_in,
    input wire logic [7:0] trace_period_in,
    input wire logic port_set_in,
    input wire logic port_usb_in,
    input wire logic comp_set_in,
    input wire logic comp_on_in,
    input wire logic factory_cal_in,
    input wire logic cal_start_in,
    input wire logic cal_entry_valid_in,
    input wire tuch_pkg::tuch_cal_axis_t cal_entry_in,
    input wire logic broadcast_set_in,
    input wire logic broadcast_on_in,
    input wire logic loop_sel_in,
    input wire logic hold_force_in,
    input wire logic hold_release_in,
    input wire logic ref_valid_in,
    input wire tuch_pkg::tuch_trace_t sensor_in,
    input wire tuch_pkg::tuch_date_t date_in,
    input wire tuch_pkg::tuch_time_t time_in,
    input wire logic [31:0] tint_pri_in,
    input wire logic [31:0] tint_sec_in,
    input wire logic almanac_in,
    input wire logic leap_future_in,
    input wire logic leap_add_in,
    input wire logic [7:0] leap_rx_offset_in,
    input wire logic [7:0] leap_nv_offset_in,
    input wire tuch_pkg::tuch_date_t leap_date_in,
    output logic resp_valid_out,
    output tuch_pkg::tuch_cmd_t resp_cmd_out,
    output logic [255:0] resp_data_out,
    output logic trace_valid_out,
    output logic trace_usb_out,
    output tuch_pkg::tuch_trace_t trace_out,
    output logic bcast_valid_out,
    output tuch_pkg::tuch_date_t bcast_date_out,
    output tuch_pkg::tuch_time_t bcast_time_out,
    output logic comp_active_out,
    output logic discipline_out,
    output logic cal_prompt_out,
    output logic [1:0] cal_axis_out,
    output logic cal_done_out,
    output tuch_pkg::tuch_cal_res_t [2:0] cal_res_out
);
    logic rst_meta, rst_sync;
    logic [31:0] tick_cnt, next_tick_cnt;
    logic [7:0] trace_period, next_trace_period, trace_cnt, next_trace_cnt;
    logic trace_usb, next_trace_usb, comp_on, next_comp_on;
    logic bcast_on, next_bcast_on, loop_sel, next_loop_sel;
    logic forced, next_forced, in_hold, next_in_hold;
    logic [31:0] sec_cnt, next_sec_cnt, hold_secs, next_hold_secs;
    tuch_pkg::tuch_state_t state, next_state;
    logic [1:0] cal_axis, next_cal_axis;
    tuch_pkg::tuch_cal_res_t [2:0] cal_res, next_cal_res;
    logic resp_valid, next_resp_valid, cal_prompt, next_cal_prompt, cal_done, next_cal_done;
    tuch_pkg::tuch_cmd_t resp_cmd, next_resp_cmd;
    logic [255:0] resp_data, next_resp_data;
    logic trace_valid, next_trace_valid;
    tuch_pkg::tuch_trace_t trace_q, next_trace_q;
    logic bcast_valid, next_bcast_valid;
    tuch_pkg::tuch_date_t bcast_date, next_bcast_date;
    tuch_pkg::tuch_time_t bcast_time, next_bcast_time;
    logic tick, sec_tick, next_comp_active, next_discipline;
    tuch_pkg::tuch_leap_t leap;
    logic [31:0] sel_tint;

    function automatic logic [15:0] two_ascii(input logic [7:0] v);
        logic [7:0] tens;
        tens = v / 8'h0A;
        two_ascii = {8'h30 + tens, 8'h30 + (v - tens * 8'h0A)};
    endfunction : two_ascii

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            rst_meta <= 1'b0;
            rst_sync <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_sync <= rst_meta;
        end
    end

    assign tick = (tick_cnt == 32'(tuch_pkg::TICK_CYCLES - 1));
    assign sec_tick = (sec_cnt == 32'(tuch_pkg::SEC_CYCLES - 1));
    // RULE19 selected loop
    assign sel_tint = loop_sel ? tint_sec_in : tint_pri_in;

    always_comb begin
        // RULE14 pending needs almanac
        leap.pending = almanac_in & leap_future_in;
        // RULE15 stored until almanac
        leap.offset = almanac_in ? leap_rx_offset_in : leap_nv_offset_in;
        leap.date = leap_date_in;
        // RULE16 final minute length
        if (!almanac_in) begin
            leap.duration = tuch_pkg::LEAP_DUR_NONE;
        end else if (!leap_future_in) begin
            leap.duration = tuch_pkg::LEAP_DUR_NORMAL;
        end else if (leap_add_in) begin
            leap.duration = tuch_pkg::LEAP_DUR_ADD;
        end else begin
            leap.duration = tuch_pkg::LEAP_DUR_SUB;
        end
    end

    always_comb begin
        next_tick_cnt = tick ? 32'h0 : tick_cnt + 32'h1;
        next_sec_cnt = sec_tick ? 32'h0 : sec_cnt + 32'h1;
        next_trace_period = trace_period;
        next_trace_cnt = trace_cnt;
        next_trace_valid = 1'b0;
        next_trace_q = trace_q;
        // RULE24 restart on change
        if (trace_set_in) begin
            next_trace_period = trace_period_in;
            next_trace_cnt = 8'h00;
            next_tick_cnt = 32'h0;
        end else if (tick && trace_period != 8'h00) begin
            // RULE1 period in 50 ms steps
            if (trace_cnt >= trace_period - 8'h01) begin
                next_trace_cnt = 8'h00;
                next_trace_valid = 1'b1;
                // RULE2 RULE3 six values from sensor path
                next_trace_q = sensor_in;
            end else begin
                next_trace_cnt = trace_cnt + 8'h01;
            end
        end
        // RULE4 destination port
        next_trace_usb = port_set_in ? port_usb_in : trace_usb;
        next_comp_on = comp_set_in ? comp_on_in : comp_on;
        next_bcast_on = broadcast_set_in ? broadcast_on_in : bcast_on;
        next_loop_sel = loop_sel_in;
        // RULE12 once per second
        next_bcast_valid = bcast_on & sec_tick;
        next_bcast_date = sec_tick ? date_in : bcast_date;
        next_bcast_time = sec_tick ? time_in : bcast_time;
        // RULE21 RULE23 force and release
        next_forced = forced;
        if (hold_force_in) begin
            next_forced = 1'b1;
        end else if (hold_release_in) begin
            next_forced = 1'b0;
        end
        // RULE20 holdover seconds, previous kept
        next_in_hold = forced | ~ref_valid_in;
        next_hold_secs = hold_secs;
        if (next_in_hold && !in_hold) begin
            next_hold_secs = 32'h0;
        end else if (in_hold && sec_tick) begin
            next_hold_secs = hold_secs + 32'h1;
        end
        // RULE5 needs factory calibration
        next_comp_active = next_comp_on & factory_cal_in;
        // RULE21 no disciplining when forced
        next_discipline = ~next_forced & ref_valid_in;
    end

    always_comb begin
        next_state = state;
        next_cal_axis = cal_axis;
        next_cal_res = cal_res;
        // RULE6 prompt per axis then compute
        case (state)
            tuch_pkg::TUCH_ST_IDLE: begin
                if (cal_start_in) begin
                    next_state = tuch_pkg::TUCH_ST_CAL;
                    next_cal_axis = 2'h0;
                end
            end
            tuch_pkg::TUCH_ST_CAL: begin
                if (cal_entry_valid_in) begin
                    // gain maps span to 2 g (value 2.0 in 16.16), offset centres zero
                    next_cal_res[cal_axis].gain =
                        16'((32'h0002_0000) / {16'h0, (cal_entry_in.max_g - cal_entry_in.min_g)
                        | 16'h0001});
                    next_cal_res[cal_axis].offset =
                        16'((17'(cal_entry_in.max_g) + 17'(cal_entry_in.min_g)) >> 1);
                    if (cal_axis == 2'h2) begin
                        next_state = tuch_pkg::TUCH_ST_DONE;
                    end else begin
                        next_cal_axis = cal_axis + 2'h1;
                    end
                end
            end
            tuch_pkg::TUCH_ST_DONE: begin
                next_state = tuch_pkg::TUCH_ST_IDLE;
            end
            default: begin
                next_state = tuch_pkg::TUCH_ST_IDLE;
            end
        endcase
        next_cal_prompt = (next_state == tuch_pkg::TUCH_ST_CAL);
        next_cal_done = (next_state == tuch_pkg::TUCH_ST_DONE);
    end

    always_comb begin
        next_resp_valid = cmd_valid_in;
        next_resp_cmd = cmd_valid_in ? cmd_in : resp_cmd;
        next_resp_data = 256'h0;
        case (cmd_in)
            // RULE7 three axes
            tuch_pkg::TUCH_CMD_ACCEL: next_resp_data = {160'h0, sensor_in[191:96]};
            // RULE8 UTC date
            tuch_pkg::TUCH_CMD_DATE: next_resp_data = {224'h0, date_in};
            // RULE9 UTC time
            tuch_pkg::TUCH_CMD_TIME: next_resp_data = {232'h0, time_in};
            // RULE10 hh:mm:ss text
            tuch_pkg::TUCH_CMD_TSTR: next_resp_data = {192'h0, two_ascii(time_in.hour),
                8'h3A, two_ascii(time_in.minute), 8'h3A, two_ascii(time_in.second)};
            // RULE11 same as loop interval
            tuch_pkg::TUCH_CMD_TINT: next_resp_data = {224'h0, sel_tint};
            tuch_pkg::TUCH_CMD_LOOP_TINT: next_resp_data = {224'h0, sel_tint};
            // RULE17 four results at once
            tuch_pkg::TUCH_CMD_LEAP: next_resp_data = {207'h0, leap};
            tuch_pkg::TUCH_CMD_LEAP_PEND: next_resp_data = {255'h0, leap.pending};
            tuch_pkg::TUCH_CMD_LEAP_ACC: next_resp_data = {248'h0, leap.offset};
            tuch_pkg::TUCH_CMD_LEAP_DATE: next_resp_data = {224'h0, leap.date};
            tuch_pkg::TUCH_CMD_LEAP_DUR: next_resp_data = {248'h0, leap.duration};
            // RULE18 five results at once
            tuch_pkg::TUCH_CMD_TIMEKEEP: next_resp_data = {159'h0, date_in, time_in,
                sel_tint, bcast_on, leap.offset};
            tuch_pkg::TUCH_CMD_HOLD_DUR: next_resp_data = {223'h0, hold_secs, in_hold};
            // RULE22 measured even when forced
            tuch_pkg::TUCH_CMD_PRI_TINT: next_resp_data = {224'h0, tint_pri_in};
            tuch_pkg::TUCH_CMD_PORT: next_resp_data = {255'h0, trace_usb};
            default: next_resp_data = 256'h0;
        endcase
    end

    always_ff @(posedge clk_in or negedge rst_sync) begin
        if (!rst_sync) begin
            tick_cnt <= 32'h0;
            sec_cnt <= 32'h0;
            trace_period <= tuch_pkg::TRACE_RST;
            trace_cnt <= 8'h00;
            trace_valid <= 1'b0;
            trace_q <= '0;
            trace_usb <= 1'b0;
            comp_on <= 1'b0;
            bcast_on <= 1'b0;
            loop_sel <= 1'b0;
            bcast_valid <= 1'b0;
            bcast_date <= '0;
            bcast_time <= '0;
            forced <= 1'b0;
            in_hold <= 1'b0;
            hold_secs <= 32'h0;
            state <= tuch_pkg::TUCH_ST_IDLE;
            cal_axis <= 2'h0;
            cal_res <= '0;
            resp_valid <= 1'b0;
            resp_cmd <= tuch_pkg::TUCH_CMD_NONE;
            resp_data <= 256'h0;
            comp_active_out <= 1'b0;
            discipline_out <= 1'b0;
            cal_prompt <= 1'b0;
            cal_done <= 1'b0;
        end else begin
            tick_cnt <= next_tick_cnt;
            sec_cnt <= next_sec_cnt;
            trace_period <= next_trace_period;
            trace_cnt <= next_trace_cnt;
            trace_valid <= next_trace_valid;
            trace_q <= next_trace_q;
            trace_usb <= next_trace_usb;
            comp_on <= next_comp_on;
            bcast_on <= next_bcast_on;
            loop_sel <= next_loop_sel;
            bcast_valid <= next_bcast_valid;
            bcast_date <= next_bcast_date;
            bcast_time <= next_bcast_time;
            forced <= next_forced;
            in_hold <= next_in_hold;
            hold_secs <= next_hold_secs;
            state <= next_state;
            cal_axis <= next_cal_axis;
            cal_res <= next_cal_res;
            resp_valid <= next_resp_valid;
            resp_cmd <= next_resp_cmd;
            resp_data <= next_resp_data;
            comp_active_out <= next_comp_active;
            discipline_out <= next_discipline;
            cal_prompt <= next_cal_prompt;
            cal_done <= next_cal_done;
        end
    end

    assign resp_valid_out = resp_valid;
    assign resp_cmd_out = resp_cmd;
    assign resp_data_out = resp_data;
    assign trace_valid_out = trace_valid;
    assign trace_usb_out = trace_usb;
    assign trace_out = trace_q;
    assign bcast_valid_out = bcast_valid;
    assign bcast_date_out = bcast_date;
    assign bcast_time_out = bcast_time;
    assign cal_prompt_out = cal_prompt;
    assign cal_axis_out = cal_axis;
    assign cal_done_out = cal_done;
    assign cal_res_out = cal_res;
endmodule : tuch_top
`default_nettype wire

// *** tuch_pkg.sv ***
// package for the timing unit command handler
package tuch_pkg;
    localparam int unsigned CLK_HZ = 50000000;
    localparam int unsigned TICK_MS = 50;
    localparam int unsigned TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
    localparam int unsigned SEC_CYCLES = CLK_HZ;
    localparam logic [7:0] TRACE_RST = 8'h00;
    localparam logic [7:0] LEAP_DUR_NONE = 8'h00;
    localparam logic [7:0] LEAP_DUR_NORMAL = 8'h3C;
    localparam logic [7:0] LEAP_DUR_ADD = 8'h3D;
    localparam logic [7:0] LEAP_DUR_SUB = 8'h3B;
    localparam logic [4:0] HOURS_PER_DAY = 5'h18;
    localparam logic [5:0] SIXTY = 6'h3C;

    typedef enum logic [3:0] {
        TUCH_CMD_NONE = 4'h0,
        TUCH_CMD_ACCEL = 4'h1,
        TUCH_CMD_DATE = 4'h2,
        TUCH_CMD_TIME = 4'h3,
        TUCH_CMD_TSTR = 4'h4,
        TUCH_CMD_TINT = 4'h5,
        TUCH_CMD_LOOP_TINT = 4'h6,
        TUCH_CMD_LEAP = 4'h7,
        TUCH_CMD_LEAP_PEND = 4'h8,
        TUCH_CMD_LEAP_ACC = 4'h9,
        TUCH_CMD_LEAP_DATE = 4'hA,
        TUCH_CMD_LEAP_DUR = 4'hB,
        TUCH_CMD_TIMEKEEP = 4'hC,
        TUCH_CMD_HOLD_DUR = 4'hD,
        TUCH_CMD_PRI_TINT = 4'hE,
        TUCH_CMD_PORT = 4'hF
    } tuch_cmd_t;

    typedef enum logic [2:0] {
        TUCH_ST_IDLE = 3'b001,
        TUCH_ST_CAL = 3'b010,
        TUCH_ST_DONE = 3'b100
    } tuch_state_t;

    typedef struct packed {
        logic [15:0] year;
        logic [7:0] month;
        logic [7:0] day;
    } tuch_date_t;

    typedef struct packed {
        logic [7:0] hour;
        logic [7:0] minute;
        logic [7:0] second;
    } tuch_time_t;

    // three axes of acceleration then three of tilt, 32-bit float each
    typedef struct packed {
        logic [31:0] ax;
        logic [31:0] ay;
        logic [31:0] az;
        logic [31:0] tx;
        logic [31:0] ty;
        logic [31:0] tz;
    } tuch_trace_t;

    typedef struct packed {
        logic pending;
        logic [7:0] offset;
        tuch_date_t date;
        logic [7:0] duration;
    } tuch_leap_t;

    typedef struct packed {
        logic [15:0] max_g;
        logic [15:0] min_g;
    } tuch_cal_axis_t;

    typedef struct packed {
        logic [15:0] gain;
        logic [15:0] offset;
    } tuch_cal_res_t;
endpackage : tuch_pkg

// *** tuch_checker.sv ***
// port assertions of the timing unit command handler
`timescale 1ns/1ps
`default_nettype none
module tuch_checker (
    input wire logic clk_in,
    input wire logic rstn_in,
    input wire logic cmd_valid_in,
    input wire tuch_pkg::tuch_cmd_t cmd_in,
    input wire logic trace_set_in,
    input wire logic [7:0] trace_period_in,
    input wire logic factory_cal_in,
    input wire logic cal_start_in,
    input wire logic cal_entry_valid_in,
    input wire logic hold_force_in,
    input wire logic hold_release_in,
    input wire logic ref_valid_in,
    input wire logic resp_valid_out,
    input wire tuch_pkg::tuch_cmd_t resp_cmd_out,
    input wire logic trace_valid_out,
    input wire logic comp_active_out,
    input wire logic discipline_out,
    input wire logic cal_prompt_out,
    input wire logic [1:0] cal_axis_out,
    input wire logic cal_done_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rstn_in);
    sequence cal_begin;
        cal_start_in && !cal_prompt_out && !cal_done_out;
    endsequence
    sequence cal_last;
        cal_entry_valid_in && cal_prompt_out && cal_axis_out == 2'h2;
    endsequence
    sequence release_held;
        (hold_release_in && !hold_force_in && ref_valid_in) ##1 (ref_valid_in && !hold_force_in) [*2];
    endsequence
    resp_follow_a: assert property (cmd_valid_in |=> resp_valid_out && resp_cmd_out == $past(cmd_in))
        else $error("query answer missing or wrong code");
    resp_quiet_a: assert property (!cmd_valid_in |=> !resp_valid_out)
        else $error("answer without a query");
    trace_off_a: assert property (trace_set_in && trace_period_in == 8'h00 |=> (!trace_valid_out) [*8])
        else $error("trace record while trace is off");
    comp_gate_a: assert property (comp_active_out |-> $past(factory_cal_in))
        else $error("compensation without factory calibration");
    force_hold_a: assert property (hold_force_in |=> !discipline_out)
        else $error("disciplining during forced holdover");
    release_hold_a: assert property (release_held |=> discipline_out)
        else $error("disciplining not resumed after release");
    cal_start_a: assert property (cal_begin |=> cal_prompt_out && cal_axis_out == 2'h0)
        else $error("calibration did not prompt for first axis");
    cal_finish_a: assert property (cal_last |-> ##[1:2] (cal_done_out ##1 !cal_done_out))
        else $error("calibration done pulse wrong");
endmodule : tuch_checker
bind tuch_top tuch_checker chk_i (.clk_in, .rstn_in, .cmd_valid_in, .cmd_in, .trace_set_in,
    .trace_period_in, .factory_cal_in, .cal_start_in, .cal_entry_valid_in, .hold_force_in,
    .hold_release_in, .ref_valid_in, .resp_valid_out, .resp_cmd_out, .trace_valid_out,
    .comp_active_out, .discipline_out, .cal_prompt_out, .cal_axis_out, .cal_done_out);
`default_nettype wire

// *** tuch_host.sv ***
// host terminal model: picks the servo loop and issues queries
`timescale 1ns/1ps
`default_nettype none
module tuch_host (
    input wire logic clk_in,
    output logic cmd_valid_out,
    output tuch_pkg::tuch_cmd_t cmd_out,
    output logic loop_sel_out
);
    initial begin
        cmd_valid_out = 1'b0;
        cmd_out = tuch_pkg::TUCH_CMD_NONE;
        loop_sel_out = 1'b0;
    end
    task automatic pick(input logic l);
        loop_sel_out <= l;
        repeat (3) @(posedge clk_in);
    endtask : pick
    // called just after an edge; back to back is legal
    task automatic send(input tuch_pkg::tuch_cmd_t c);
        cmd_valid_out <= 1'b1;
        cmd_out <= c;
        @(posedge clk_in);
    endtask : send
    // idle code is inverted so a stale value is not repeated; the inverted code is still a defined command code
    task automatic rest;
        cmd_valid_out <= 1'b0;
        cmd_out <= tuch_pkg::tuch_cmd_t'(~cmd_out);
    endtask : rest
endmodule : tuch_host
`default_nettype wire

// *** tuch_top_test.sv ***
// self-checking bench of the timing unit command handler
`timescale 1ns/1ps
`default_nettype none
module tuch_top_test;
    logic clk, rstn, cv, tset, pset, pusb, cset, con, fcal, cst, cev, bset, bon, lsel;
    logic hf, hr, rok, alm, lfut, ladd, rv, tv, tusb, bv, ca, disc, cp, cd, frc;
    logic [7:0] tper, rxo, nvo;
    logic [31:0] tp, ts;
    logic [1:0] cax;
    logic [15:0] mx, mn;
    logic [259:0] e;
    logic [259:0] expq[$];
    logic [255:0] rdata;
    tuch_pkg::tuch_cmd_t cmd, rcmd;
    tuch_pkg::tuch_cal_axis_t cale;
    tuch_pkg::tuch_trace_t sens;
    tuch_pkg::tuch_date_t date, ldate;
    tuch_pkg::tuch_time_t tim;
    tuch_pkg::tuch_cal_res_t [2:0] cres, ecal;
    int num_errors = 0, compares = 0, cycles = 0, w;
    integer seed = 32'h15749A9D;
    tuch_host host (.clk_in(clk), .cmd_valid_out(cv), .cmd_out(cmd), .loop_sel_out(lsel));
    tuch_top uut (.clk_in(clk), .rstn_in(rstn), .cmd_valid_in(cv), .cmd_in(cmd),
        .trace_set_in(tset), .trace_period_in(tper), .port_set_in(pset), .port_usb_in(pusb),
        .comp_set_in(cset), .comp_on_in(con), .factory_cal_in(fcal), .cal_start_in(cst),
        .cal_entry_valid_in(cev), .cal_entry_in(cale), .broadcast_set_in(bset),
        .broadcast_on_in(bon), .loop_sel_in(lsel), .hold_force_in(hf), .hold_release_in(hr),
        .ref_valid_in(rok), .sensor_in(sens), .date_in(date), .time_in(tim), .tint_pri_in(tp),
        .tint_sec_in(ts), .almanac_in(alm), .leap_future_in(lfut), .leap_add_in(ladd),
        .leap_rx_offset_in(rxo), .leap_nv_offset_in(nvo), .leap_date_in(ldate),
        .resp_valid_out(rv), .resp_cmd_out(rcmd), .resp_data_out(rdata),
        .trace_valid_out(tv), .trace_usb_out(tusb), .trace_out(), .bcast_valid_out(bv),
        .bcast_date_out(), .bcast_time_out(), .comp_active_out(ca), .discipline_out(disc),
        .cal_prompt_out(cp), .cal_axis_out(cax), .cal_done_out(cd), .cal_res_out(cres));
    task automatic chk(input string what, input logic [255:0] got, input logic [255:0] want);
        compares++;
        if (got !== want) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", what, want, got);
        end
    endtask : chk
    task automatic give_verdict;
        $display("compares %0d num_errors %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : give_verdict
    function automatic logic [15:0] two(input logic [7:0] v);
        return {8'h30 + v / 8'h0A, 8'h30 + v % 8'h0A};
    endfunction : two
    function automatic logic [255:0] want_of(input tuch_pkg::tuch_cmd_t c);
        logic pend;
        logic [7:0] acc, dur;
        logic [31:0] ti;
        pend = alm & lfut;
        acc = alm ? rxo : nvo;
        dur = !alm ? 8'h00 : !pend ? 8'h3C : ladd ? 8'h3D : 8'h3B;
        ti = lsel ? ts : tp;
        case (c)
            tuch_pkg::TUCH_CMD_ACCEL: return 256'(sens[191:96]);
            tuch_pkg::TUCH_CMD_DATE: return 256'(date);
            tuch_pkg::TUCH_CMD_TIME: return 256'(tim);
            tuch_pkg::TUCH_CMD_TSTR: return 256'({two(tim.hour), 8'h3A, two(tim.minute), 8'h3A,
                two(tim.second)});
            tuch_pkg::TUCH_CMD_TINT, tuch_pkg::TUCH_CMD_LOOP_TINT: return 256'(ti);
            tuch_pkg::TUCH_CMD_LEAP: return 256'({pend, acc, ldate, dur});
            tuch_pkg::TUCH_CMD_LEAP_PEND: return 256'(pend);
            tuch_pkg::TUCH_CMD_LEAP_ACC: return 256'(acc);
            tuch_pkg::TUCH_CMD_LEAP_DATE: return 256'(ldate);
            tuch_pkg::TUCH_CMD_LEAP_DUR: return 256'(dur);
            tuch_pkg::TUCH_CMD_TIMEKEEP: return 256'({date, tim, ti, bon, acc});
            tuch_pkg::TUCH_CMD_HOLD_DUR: return 256'({32'h0, frc | !rok});
            tuch_pkg::TUCH_CMD_PRI_TINT: return 256'(tp);
            tuch_pkg::TUCH_CMD_PORT: return 256'(1'b1);
            default: return 256'h0;
        endcase
    endfunction : want_of
    task automatic ask(input int c);
        expq.push_back({4'(c), want_of(tuch_pkg::tuch_cmd_t'(c))});
        host.send(tuch_pkg::tuch_cmd_t'(c));
    endtask : ask
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // responses are matched against the oldest note
    always @(posedge clk) begin
        cycles++;
        if (rstn === 1'b1 && bv !== 1'b0) chk("broadcast pulse", 256'(bv), 256'h0);
        // trace stays off at period zero
        if (rstn === 1'b1 && tv !== 1'b0) chk("trace pulse", 256'(tv), 256'h0);
        if (rstn === 1'b1 && rv !== 1'b0) begin
            e = (expq.size() > 0) ? expq.pop_front() : '1;
            chk("answer code", 256'(rcmd), 256'(e[259:256]));
            chk("answer data", rdata, e[255:0]);
        end
        // limit sits last so nothing runs after the verdict
        if (cycles > 3000) begin
            num_errors++;
            give_verdict();
        end
    end
    initial begin
        {rstn, tset, pset, pusb, cset, con, fcal, cst, cev, bset, bon, hf, hr} = '0;
        {rok, alm, lfut, ladd, frc, tper, rxo, nvo, tp, ts} = '0;
        {cale, sens, date, ldate, tim} = '0;
        repeat (10) @(posedge clk);
        rstn <= 1'b1;
        repeat (3) @(posedge clk);
        {bon, bset, pusb, pset, con, cset, tset} <= 7'h7F;
        @(posedge clk);
        {bset, pset, cset, tset} <= 4'h0;
        repeat (2) @(posedge clk);
        chk("trace port", 256'(tusb), 256'h1);
        for (int r = 0; r < 6; r++) begin
            sens <= {$random(seed), $random(seed), $random(seed), $random(seed), $random(seed),
                $random(seed)};
            {date, ldate, tp, ts, rxo, nvo} <= {$random(seed), $random(seed), $random(seed),
                $random(seed), 16'($random(seed))};
            tim <= {8'($unsigned($random(seed)) % 24), 8'($unsigned($random(seed)) % 60),
                8'($unsigned($random(seed)) % 60)};
            {alm, lfut, ladd, fcal, rok} <= 5'($random(seed));
            host.pick(1'($random(seed)));
            chk("comp active", 256'(ca), 256'(fcal));
            chk("discipline", 256'(disc), 256'(rok));
            for (int k = 1; k < 16; k++) ask(k);
            host.rest();
            @(posedge clk);
        end
        // force and release together: force wins
        {rok, hf, hr} <= 3'h7;
        @(posedge clk);
        {hf, hr} <= 2'h0;
        frc = 1'b1;
        repeat (3) @(posedge clk);
        chk("forced discipline", 256'(disc), 256'h0);
        ask(tuch_pkg::TUCH_CMD_HOLD_DUR);
        ask(tuch_pkg::TUCH_CMD_PRI_TINT);
        host.rest();
        hr <= 1'b1;
        @(posedge clk);
        hr <= 1'b0;
        frc = 1'b0;
        repeat (3) @(posedge clk);
        chk("released discipline", 256'(disc), 256'h1);
        ask(tuch_pkg::TUCH_CMD_HOLD_DUR);
        host.rest();
        cst <= 1'b1;
        @(posedge clk);
        cst <= 1'b0;
        @(posedge clk);
        for (int a = 0; a < 3; a++) begin
            mx = 16'h4000 | 16'($random(seed) & 32'h0FFF);
            mn = 16'h1000 | 16'($random(seed) & 32'h0FFF);
            ecal[a] = {16'(32'h20000 / 32'((mx - mn) | 16'h1)), 16'((17'(mx) + 17'(mn)) >> 1)};
            chk("cal prompt axis", 256'({cp, cax}), 256'({1'b1, 2'(a)}));
            cale <= {mx, mn};
            cev <= 1'b1;
            @(posedge clk);
            cev <= 1'b0;
            @(posedge clk);
        end
        for (w = 0; w < 10 && cd !== 1'b1; w++) @(posedge clk);
        chk("cal done", 256'(cd), 256'h1);
        @(posedge clk);
        chk("cal result", 256'(cres), 256'(ecal));
        repeat (3) @(posedge clk);
        chk("answers left", 256'(expq.size()), 256'h0);
        give_verdict();
    end
endmodule : tuch_top_test
`default_nettype wire
